// [fisrc_map.svh]
`ifndef FISRC_MAP_SVH
`define FISRC_MAP_SVH
// ==========================================
// Opcodes
`define FISRC_OP_RELEASE   8'hab
`define FISRC_OP_SEC_READ  8'h48
`define FISRC_OP_SEC_ERASE 8'h44
`define FISRC_OP_SEC_PROG  8'h42
`define FISRC_OP_RST_EN    8'h66
`define FISRC_OP_RST       8'h99
`define FISRC_OP_WREN      8'h06
`define FISRC_OP_PWR_DOWN  8'hb9
// ==========================================
// Frame bit counts (header counter saturates)
`define FISRC_OPC_BITS     6'h08
`define FISRC_ADDR_BITS    6'h20
`define FISRC_SAT_BITS     6'h28
`define FISRC_OPC_LAST     6'h07
`define FISRC_ADDR_LAST    6'h1f
`define FISRC_DUMMY_LAST   6'h27
// ==========================================
// Address fields and reset values
`define FISRC_ERASED       8'hff
`define FISRC_SEL_ALL      3'h7
// ==========================================
// Timing, times in us, counts in clk cycles
`define FISRC_CLK_MHZ      25
`define FISRC_RELEASE_US   3
`define FISRC_RELEASE_ID_US 5
`define FISRC_RESET_US     30
`define FISRC_PROG_US      1000
`define FISRC_ERASE_US     10000
`define FISRC_RELEASE_CYC    (`FISRC_RELEASE_US * `FISRC_CLK_MHZ)
`define FISRC_RELEASE_ID_CYC (`FISRC_RELEASE_ID_US * `FISRC_CLK_MHZ)
`define FISRC_RESET_CYC      (`FISRC_RESET_US * `FISRC_CLK_MHZ)
`define FISRC_PROG_CYC       (`FISRC_PROG_US * `FISRC_CLK_MHZ)
`define FISRC_ERASE_CYC      (`FISRC_ERASE_US * `FISRC_CLK_MHZ)
`endif

// [fisrc_pkg.sv]
package fisrc_pkg;
  // ==========================================
  // Command engine states
  typedef enum logic [1:0] {
    st_idle    = 2'b00,
    st_busy    = 2'b01,
    st_recover = 2'b10
  } fisrc_state_type;
  // Frame summary left by the link side
  typedef struct packed {
    logic [7:0]  opcode;
    logic [23:0] addr;
    logic [5:0]  hdr;
    logic [2:0]  bcnt;
  } fisrc_frame_type;
  // Permissions handed to the link side
  typedef struct packed {
    logic id_ok;
    logic rd_ok;
  } fisrc_perm_type;
endpackage

// [fisrc_core.sv]
`timescale 1ns/1ns
`include "fisrc_map.svh"
module fisrc_core #(
  parameter logic [7:0]  DEVICE_ID      = 8'h5a, // Arbitrary identification value
  parameter int unsigned RELEASE_CYC    = `FISRC_RELEASE_CYC,
  parameter int unsigned RELEASE_ID_CYC = `FISRC_RELEASE_ID_CYC,
  parameter int unsigned RESET_CYC      = `FISRC_RESET_CYC,
  parameter int unsigned PROG_CYC       = `FISRC_PROG_CYC,
  parameter int unsigned ERASE_CYC      = `FISRC_ERASE_CYC
) (
  // System clock and reset
  input  wire logic       clk,
  input  wire logic       srst,
  // Serial link
  input  wire logic       sclk,
  input  wire logic       cs_n,
  input  wire logic       mosi,
  output logic            miso,
  output logic            miso_oe,
  // Lock bits, one per security register
  input  wire logic [2:0] secreg_lock_bits,
  // Status
  output logic            write_in_progress,
  output logic            write_enable_latch,
  output logic            deep_power_down,
  output logic            reset_armed,
  output logic            cmd_blocked,
  output logic            sw_reset_pulse
);

  // ==========================================
  // Parameter checks
  generate
    if (PROG_CYC < 256 || ERASE_CYC < 256 || RELEASE_CYC < 1 ||
        RELEASE_ID_CYC < 1 || RESET_CYC < 1) begin : g_bad_timing
      $error("Busy counts must cover the 256-cycle copy");
    end
  endgenerate

  // register select field
  // Register select decode, zero when invalid
  function automatic logic [1:0] sel_of(input logic [23:0] a);
    sel_of = 2'h0;
    if (a[23:16] == 8'h00 && a[11:8] == 4'h0 && a[15:14] == 2'h0)
      sel_of = a[13:12];
  endfunction

  // One-hot register mask from a select
  function automatic logic [2:0] mask_of(input logic [1:0] s);
    unique case (s)
      2'h1:    mask_of = 3'h1;
      2'h2:    mask_of = 3'h2;
      2'h3:    mask_of = 3'h4;
      default: mask_of = 3'h0;
    endcase
  endfunction

  // ==========================================
  // Storage
  // one array holding all three registers
  logic [7:0] mem [1:3][0:255];
  logic [7:0] pbuf [0:255];
  logic [255:0] pmask;

  // ==========================================
  // Link side state
  logic        link_rst;
  logic        started;
  logic [5:0]  hdr, next_hdr, b_hdr;
  logic [2:0]  bcnt, next_bcnt, b_bcnt;
  logic [7:0]  sh, next_sh, byte_in;
  logic [7:0]  opc, next_opc;
  logic [23:0] addr, next_addr;
  logic [7:0]  ptr, next_ptr;
  logic [7:0]  pofs, next_pofs;
  logic        rd_go, next_rd_go;
  logic        rd_id, next_rd_id;
  logic        pgo, next_pgo;
  logic        pclr, pwr;
  logic [1:0]  rsel;
  logic [7:0]  obyte;
  logic [7:0]  osh, next_osh;
  logic        next_miso, next_oe;
  fisrc_pkg::fisrc_perm_type perm, pm_meta, pm;

  // Frame gate, cleared while deselected
  assign link_rst = cs_n | srst;

  // Marks that the frame has seen a rising edge
  always_ff @(posedge sclk or posedge link_rst) begin
    if (link_rst) begin
      started <= 1'b0;
    end else begin
      started <= 1'b1;
    end
  end

  // Rising edge decode of the incoming frame
  always_comb begin
    b_hdr      = started ? hdr : 6'h00;
    b_bcnt     = started ? bcnt : 3'h0;
    byte_in    = {sh[6:0], mosi};
    next_sh    = byte_in;
    next_bcnt  = b_bcnt + 3'h1;
    next_hdr   = (b_hdr == `FISRC_SAT_BITS) ? b_hdr : b_hdr + 6'h01;
    next_opc   = (b_hdr == `FISRC_OPC_LAST) ? byte_in : opc;
    next_addr  = (b_hdr >= `FISRC_OPC_BITS && b_hdr < `FISRC_ADDR_BITS) ? {addr[22:0], mosi} : addr;
    next_rd_go = started & rd_go;
    next_rd_id = started & rd_id;
    next_pgo   = started & pgo;
    next_ptr   = ptr;
    next_pofs  = pofs;
    pclr       = 1'b0;
    pwr        = 1'b0;
    if (b_hdr == `FISRC_ADDR_LAST && opc == `FISRC_OP_RELEASE && pm.id_ok) begin
      next_rd_go = 1'b1;
      next_rd_id = 1'b1;
    end
    // data after address and dummy byte
    if (b_hdr == `FISRC_DUMMY_LAST && opc == `FISRC_OP_SEC_READ && pm.rd_ok && sel_of(addr) != 2'h0) begin
      next_rd_go = 1'b1;
    end
    if (b_hdr == `FISRC_ADDR_LAST) begin
      next_ptr = next_addr[7:0];
    end else if (started && rd_go && !rd_id && b_bcnt == 3'h7) begin
      next_ptr = ptr + 8'h01;
    end
    if (b_hdr == `FISRC_ADDR_LAST && opc == `FISRC_OP_SEC_PROG && pm.rd_ok && sel_of(next_addr) != 2'h0) begin
      next_pgo  = 1'b1;
      pclr      = 1'b1;
      next_pofs = next_addr[7:0];
    end
    if (started && pgo && b_bcnt == 3'h7) begin
      pwr       = 1'b1;
      next_pofs = pofs + 8'h01;
    end
  end

  // Rising edge registers and permission synchroniser
  always_ff @(posedge sclk) begin
    hdr     <= next_hdr;
    bcnt    <= next_bcnt;
    sh      <= next_sh;
    opc     <= next_opc;
    addr    <= next_addr;
    ptr     <= next_ptr;
    pofs    <= next_pofs;
    rd_go   <= next_rd_go;
    rd_id   <= next_rd_id;
    pgo     <= next_pgo;
    pm_meta <= perm;
    pm      <= pm_meta;
  end

  // Program buffer, later data overwrites earlier
  always_ff @(posedge sclk) begin
    if (pclr) begin
      pmask <= '0;
    end
    if (pwr) begin
      pbuf[pofs]  <= byte_in;
      pmask[pofs] <= 1'b1;
    end
  end

  // Falling edge output shifter
  always_comb begin
    rsel      = sel_of(addr);
    obyte     = `FISRC_ERASED;
    if (rd_id) begin
      obyte = DEVICE_ID;
    end else if (rsel != 2'h0) begin
      obyte = mem[rsel][ptr];
    end
    next_oe   = started & rd_go;
    next_miso = miso;
    next_osh  = osh;
    if (started && rd_go) begin
      if (bcnt == 3'h0) begin
        {next_miso, next_osh} = {obyte, 1'b0};
      end else begin
        {next_miso, next_osh} = {osh, 1'b0};
      end
    end
  end

  // Output flops, released by deselect
  always_ff @(negedge sclk or posedge link_rst) begin
    if (link_rst) begin
      miso    <= 1'b0;
      miso_oe <= 1'b0;
      osh     <= 8'h00;
    end else begin
      miso    <= next_miso;
      miso_oe <= next_oe;
      osh     <= next_osh;
    end
  end

  // ==========================================
  // Command engine on the system clock
  fisrc_pkg::fisrc_state_type st, next_st;
  fisrc_pkg::fisrc_frame_type fr;
  fisrc_pkg::fisrc_perm_type  next_perm;
  logic        cs_meta, cs_sync, cs_prev, cs_rise;
  logic [31:0] tmr, next_tmr, lim, next_lim;
  logic        erase_op, next_erase_op;
  logic [2:0]  tgt, next_tgt, etgt;
  logic [1:0]  psel, next_psel, fsel;
  logic        next_wip, next_wel, next_pd, next_armed, next_blk, next_pulse;
  logic        is8, start;

  // Frame summary is stable while select is high
  assign fr      = {opc, addr, hdr, bcnt};
  assign cs_rise = cs_sync & ~cs_prev;

  // Next state of the command engine
  always_comb begin
    next_st       = st;
    next_tmr      = tmr;
    next_lim      = lim;
    next_erase_op = erase_op;
    next_tgt      = tgt;
    next_psel     = psel;
    next_wip      = write_in_progress;
    next_wel      = write_enable_latch;
    next_pd       = deep_power_down;
    next_armed    = reset_armed;
    next_pulse    = 1'b0;
    is8           = fr.hdr == `FISRC_OPC_BITS;
    fsel          = sel_of(fr.addr);
    etgt          = 3'h0;
    start         = 1'b0;
    if (st != fisrc_pkg::st_idle) begin
      if (tmr == lim - 32'h1) begin
        next_st  = fisrc_pkg::st_idle;
        next_wip = 1'b0;
      end else begin
        next_tmr = tmr + 32'h1;
      end
    end
    if (cs_rise && st != fisrc_pkg::st_recover && fr.hdr != 6'h00) begin
      if (deep_power_down) begin
        if (fr.opcode == `FISRC_OP_RELEASE && fr.hdr >= `FISRC_OPC_BITS) begin
          next_pd  = 1'b0;
          next_st  = fisrc_pkg::st_recover;
          next_tmr = 32'h0;
          next_lim = is8 ? RELEASE_CYC : RELEASE_ID_CYC;
        end
      end else begin
        next_armed = is8 && fr.opcode == `FISRC_OP_RST_EN;
        if (reset_armed && is8 && fr.opcode == `FISRC_OP_RST) begin
          next_st    = fisrc_pkg::st_recover;
          next_tmr   = 32'h0;
          next_lim   = RESET_CYC;
          next_wip   = 1'b0;
          next_wel   = 1'b0;
          next_pulse = 1'b1;
        end else if (st == fisrc_pkg::st_idle) begin
          unique case (fr.opcode)
            `FISRC_OP_WREN: begin
              next_wel = next_wel | is8;
            end
            `FISRC_OP_PWR_DOWN: begin
              next_pd = is8;
            end
            `FISRC_OP_SEC_ERASE: begin
              // deselect right after opcode, write enable needed
              if (is8) begin
                etgt = `FISRC_SEL_ALL;
              end else if (fr.hdr == `FISRC_ADDR_BITS && fr.bcnt == 3'h0) begin
                etgt = mask_of(fsel);
              end
              if (write_enable_latch && etgt != 3'h0 && (etgt & secreg_lock_bits) == 3'h0) begin
                start         = 1'b1;
                next_erase_op = 1'b1;
                next_tgt      = etgt;
                next_lim      = ERASE_CYC;
              end
            end
            `FISRC_OP_SEC_PROG: begin
              if (write_enable_latch && fr.hdr == `FISRC_SAT_BITS && fr.bcnt == 3'h0 &&
                  fsel != 2'h0 && (mask_of(fsel) & secreg_lock_bits) == 3'h0) begin
                start         = 1'b1;
                next_erase_op = 1'b0;
                next_psel     = fsel;
                next_lim      = PROG_CYC;
              end
            end
            default: begin
              next_wel = next_wel;
            end
          endcase
        end
      end
    end
    // cycle start shows busy and drops write enable
    if (start) begin
      next_st  = fisrc_pkg::st_busy;
      next_tmr = 32'h0;
      next_wip = 1'b1;
      next_wel = 1'b0;
    end
    next_blk        = next_st == fisrc_pkg::st_recover;
    next_perm.id_ok = next_st == fisrc_pkg::st_idle;
    next_perm.rd_ok = next_st == fisrc_pkg::st_idle && !next_pd;
  end

  // Command engine registers
  always_ff @(posedge clk) begin
    cs_meta <= cs_n;
    cs_sync <= cs_meta;
    if (srst) begin
      cs_prev            <= 1'b1;
      st                 <= fisrc_pkg::st_idle;
      tmr                <= 32'h0;
      lim                <= 32'h1;
      erase_op           <= 1'b0;
      tgt                <= 3'h0;
      psel               <= 2'h0;
      write_in_progress  <= 1'b0;
      write_enable_latch <= 1'b0;
      deep_power_down    <= 1'b0;
      reset_armed        <= 1'b0;
      cmd_blocked        <= 1'b0;
      sw_reset_pulse     <= 1'b0;
      perm               <= 2'h0;
    end else begin
      cs_prev            <= cs_sync;
      st                 <= next_st;
      tmr                <= next_tmr;
      lim                <= next_lim;
      erase_op           <= next_erase_op;
      tgt                <= next_tgt;
      psel               <= next_psel;
      write_in_progress  <= next_wip;
      write_enable_latch <= next_wel;
      deep_power_down    <= next_pd;
      reset_armed        <= next_armed;
      cmd_blocked        <= next_blk;
      sw_reset_pulse     <= next_pulse;
      perm               <= next_perm;
    end
  end

  // Array update, one byte per target register per cycle in the first 256 busy cycles
  always_ff @(posedge clk) begin
    if (!srst && st == fisrc_pkg::st_busy && tmr < 32'h100) begin
      for (int t = 1; t <= 3; t++) begin
        if (erase_op && tgt[t-1]) begin
          mem[t][tmr[7:0]] <= `FISRC_ERASED;
        end else if (!erase_op && psel == 2'(t) && pmask[tmr[7:0]]) begin
          mem[t][tmr[7:0]] <= mem[t][tmr[7:0]] & pbuf[tmr[7:0]];
        end
      end
    end
  end

endmodule

// [fisrc_host.sv]
`timescale 1ns/1ns
// ==========
// Host serial controller model, 64 ns link clock
module fisrc_host (
  // Link pins
  output logic      sclk,
  output logic      cs_n,
  output logic      mosi,
  input  wire logic miso,
  input  wire logic miso_oe
);
  logic [7:0] tx[$];
  logic [7:0] rx[$];
  logic       seen_oe;

  // Idle link: clock parked low, deselected
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    mosi = 1'b0;
  end

  // One bit: data set after the falling edge, miso taken at the rising edge
  task automatic bit_io(input logic v, inout logic [7:0] b);
    mosi = v;
    #32 sclk = 1'b1;
    b = {b[6:0], miso};
    seen_oe = seen_oe | miso_oe;
    #32 sclk = 1'b0;
  endtask

  // One frame: tx bytes, xb extra bits, nr bytes read back
  task automatic run(input int xb, input int nr);
    logic [7:0] b;
    rx = {};
    seen_oe = 1'b0;
    cs_n = 1'b0;
    foreach (tx[i]) for (int k = 7; k >= 0; k--) bit_io(tx[i][k], b);
    for (int k = 0; k < xb; k++) bit_io(1'b1, b);
    for (int j = 0; j < nr; j++) begin
      for (int k = 0; k < 8; k++) bit_io(1'b0, b);
      rx.push_back(b);
    end
    #32 cs_n = 1'b1;
    mosi = ~mosi;
    #320;
  endtask
endmodule

// [fisrc_core_properties.sv]
`timescale 1ns/1ns
// ==========
// Port checker for the command engine
module fisrc_core_properties #(
  parameter int unsigned RELEASE_CYC    = 75,
  parameter int unsigned RELEASE_ID_CYC = 125,
  parameter int unsigned RESET_CYC      = 750
) (
  // Clock and reset
  input wire logic       clk,
  input wire logic       srst,
  // Serial link
  input wire logic       sclk,
  input wire logic       cs_n,
  input wire logic       mosi,
  input wire logic       miso,
  input wire logic       miso_oe,
  // Lock bits
  input wire logic [2:0] secreg_lock_bits,
  // Status
  input wire logic       write_in_progress,
  input wire logic       write_enable_latch,
  input wire logic       deep_power_down,
  input wire logic       reset_armed,
  input wire logic       cmd_blocked,
  input wire logic       sw_reset_pulse
);
  int unsigned blk_len;
  int unsigned next_blk_len;
  logic        len_ok;

  default clocking @(posedge clk); endclocking
  default disable iff (srst);

  // Length of the running recovery window
  always_comb begin
    next_blk_len = cmd_blocked ? blk_len + 1 : 0;
  end
  always_ff @(posedge clk) begin
    blk_len <= srst ? 0 : next_blk_len;
  end
  // Window length within one clock of a recovery count
  assign len_ok = (blk_len + 1 >= RELEASE_CYC && blk_len <= RELEASE_CYC + 1) ||
                  (blk_len + 1 >= RELEASE_ID_CYC && blk_len <= RELEASE_ID_CYC + 1) ||
                  (blk_len + 1 >= RESET_CYC && blk_len <= RESET_CYC + 1);

  sequence s_reinit;
    cmd_blocked [*8];
  endsequence
  property p_reset_idle;
    $fell(srst) |-> !(write_in_progress | write_enable_latch | deep_power_down | reset_armed |
                      cmd_blocked | sw_reset_pulse | miso_oe);
  endproperty
  property p_oe_idle;
    cs_n && $past(cs_n) |-> !miso_oe;
  endproperty
  property p_pulse_one;
    sw_reset_pulse |=> !sw_reset_pulse;
  endproperty
  property p_arm_first;
    $rose(sw_reset_pulse) |-> $past(reset_armed);
  endproperty
  property p_reset_clears;
    sw_reset_pulse |-> ##[0:1] (!write_in_progress && !write_enable_latch);
  endproperty
  property p_reinit;
    $rose(sw_reset_pulse) |-> ##[0:1] s_reinit;
  endproperty
  property p_window_len;
    $fell(cmd_blocked) |-> len_ok;
  endproperty
  property p_blocked_quiet;
    cmd_blocked |-> !$rose(write_in_progress);
  endproperty
  property p_pd_quiet;
    deep_power_down |-> !$rose(write_in_progress);
  endproperty
  property p_wake;
    $fell(deep_power_down) |-> cmd_blocked;
  endproperty
  property p_busy_start;
    $rose(write_in_progress) |-> $past(write_enable_latch) && !write_enable_latch;
  endproperty
  property p_busy_no_release;
    $rose(cmd_blocked) |-> sw_reset_pulse || $past(sw_reset_pulse) || !$past(write_in_progress);
  endproperty

  a_reset_idle: assert property (p_reset_idle)
    else $error("status not idle after reset");
  a_oe_idle: assert property (p_oe_idle)
    else $error("output driven while deselected");
  a_pulse_one: assert property (p_pulse_one)
    else $error("reset pulse longer than one clock");
  a_arm_first: assert property (p_arm_first)
    else $error("reset without arming");
  a_reset_clears: assert property (p_reset_clears)
    else $error("reset left busy or write enable");
  a_reinit: assert property (p_reinit)
    else $error("reinitialise window missing");
  a_window_len: assert property (p_window_len)
    else $error("recovery window length wrong");
  a_blocked_quiet: assert property (p_blocked_quiet)
    else $error("command run during recovery");
  a_pd_quiet: assert property (p_pd_quiet)
    else $error("command run in power-down");
  a_wake: assert property (p_wake)
    else $error("wake without recovery");
  a_busy_start: assert property (p_busy_start)
    else $error("cycle start without write enable");
  a_busy_no_release: assert property (p_busy_no_release)
    else $error("release accepted while busy");
endmodule

// [fisrc_core_bench.sv]
`timescale 1ns/1ns
// ==========
// Bench top: host model, core, reference memory
module fisrc_core_bench;
  localparam int         RC = 20, RIC = 30, SC = 40, PC = 300, EC = 600;
  localparam logic [7:0] ID = 8'h3c; // Arbitrary identification value
  logic       clk, srst, sclk, cs_n, mosi, miso, miso_oe;
  logic       write_in_progress, write_enable_latch, deep_power_down;
  logic       reset_armed, cmd_blocked, sw_reset_pulse;
  logic [2:0] secreg_lock_bits;
  logic [7:0] mem[3][256];
  logic [7:0] d, hi;
  int         err_total, checked, seed, n, sel;

  // System clock
  always #20 clk = ~clk;

  fisrc_core #(.DEVICE_ID(ID), .RELEASE_CYC(RC), .RELEASE_ID_CYC(RIC), .RESET_CYC(SC),
    .PROG_CYC(PC), .ERASE_CYC(EC)) dut (.clk, .srst, .sclk, .cs_n, .mosi, .miso, .miso_oe,
    .secreg_lock_bits, .write_in_progress, .write_enable_latch, .deep_power_down,
    .reset_armed, .cmd_blocked, .sw_reset_pulse);
  fisrc_host h (.sclk, .cs_n, .mosi, .miso, .miso_oe);

  // Verdict and end of run
  task automatic test_done();
    $display("checked %0d err_total %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // Compare one value
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (e !== g) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", s, e, g);
    end
  endtask

  // One frame, then back to the falling clock edge
  task automatic go(input logic [7:0] b[$], input int xb = 0, input int nr = 0);
    h.tx = b;
    h.run(xb, nr);
    @(negedge clk);
  endtask

  // Clocks until the flag drops, bounded
  task automatic dur(input bit blk);
    n = 0;
    while ((blk ? cmd_blocked : write_in_progress) === 1'b1 && n < 999) begin
      @(negedge clk);
      n++;
    end
    if (n >= 999) begin
      err_total++;
      test_done();
    end
  endtask

  // Main sequence
  initial begin
    clk = 1'b0;
    srst = 1'b1;
    secreg_lock_bits = 3'h0;
    err_total = 0;
    checked = 0;
    seed = 32'he922;
    repeat (3) @(negedge clk);
    srst = 1'b0;
    repeat (3) @(negedge clk);
    // Erase: broken frame, locked, then all three
    go('{8'h06});
    go('{8'h44}, 1);
    chk("wip", 0, write_in_progress);
    secreg_lock_bits = 3'h4;
    go('{8'h44});
    chk("wip", 0, write_in_progress);
    secreg_lock_bits = 3'h0;
    go('{8'h44});
    chk("wel", 0, write_enable_latch);
    dur(0);
    chk("erase time", 1, n >= EC - 7 && n <= EC - 2);
    foreach (mem[i, j]) mem[i][j] = 8'hff;
    // Program four random bytes across the wrap, identification refused meanwhile
    sel = 1 + $unsigned($random(seed)) % 3;
    hi = 8'(sel << 4);
    go('{8'h06});
    h.tx = '{8'h42, 8'h00, hi, 8'hfe};
    for (int i = 0; i < 4; i++) begin
      d = 8'($random(seed));
      h.tx.push_back(d);
      mem[sel - 1][8'(254 + i)] &= d;
    end
    h.run(0, 0);
    chk("wip", 1, write_in_progress);
    go('{8'hab, 8'h00, 8'h00, 8'h00}, 0, 1);
    chk("oe", 0, h.seen_oe);
    dur(0);
    chk("prog time", 1, n > PC - 150 && n < PC - 50);
    secreg_lock_bits = 3'(1 << (sel - 1));
    go('{8'h06});
    go('{8'h42, 8'h00, hi, 8'h00, 8'h00});
    chk("wip", 0, write_in_progress);
    secreg_lock_bits = 3'h0;
    // Read back with wrap, bad address, identification
    go('{8'h48, 8'h00, hi, 8'hfe, 8'h00}, 0, 5);
    for (int i = 0; i < 5; i++) chk("read", mem[sel - 1][8'(254 + i)], h.rx[i]);
    go('{8'h48, 8'h00, 8'h40, 8'h00, 8'h00}, 0, 1);
    chk("oe", 0, h.seen_oe);
    go('{8'hab, 8'h00, 8'h00, 8'h00}, 0, 2);
    chk("id", {ID, ID}, {h.rx[0], h.rx[1]});
    // Erase one register by address while another one is locked
    secreg_lock_bits = 3'(1 << (sel % 3));
    go('{8'h06});
    go('{8'h44, 8'h00, hi, 8'h00});
    chk("wip", 1, write_in_progress);
    dur(0);
    secreg_lock_bits = 3'h0;
    for (int j = 0; j < 256; j++) mem[sel - 1][j] = 8'hff;
    go('{8'h48, 8'h00, hi, 8'hff, 8'h00}, 0, 2);
    for (int i = 0; i < 2; i++) chk("read", mem[sel - 1][8'(255 + i)], h.rx[i]);
    // Reset aborting a program cycle, after one disarm
    go('{8'h06});
    go('{8'h42, 8'h00, hi, 8'h00, 8'h00});
    chk("wip", 1, write_in_progress);
    go('{8'h66});
    chk("armed", 1, reset_armed);
    go('{8'h06});
    chk("armed", 0, reset_armed);
    go('{8'h66});
    go('{8'h99});
    chk("wip", 0, write_in_progress);
    go('{8'h06});
    chk("wel", 0, write_enable_latch);
    dur(1);
    chk("reset time", 1, n > 0 && n < SC);
    // Power-down, release only, release with identification
    go('{8'hb9});
    go('{8'h48, 8'h00, hi, 8'h00, 8'h00}, 0, 1);
    chk("oe", 0, h.seen_oe);
    go('{8'hab});
    chk("pd", 0, deep_power_down);
    dur(1);
    chk("release time", 1, n >= RC - 7 && n <= RC - 2);
    go('{8'hb9});
    go('{8'hab, 8'h00, 8'h00, 8'h00}, 0, 1);
    chk("id", ID, h.rx[0]);
    dur(1);
    chk("id release time", 1, n >= RIC - 7 && n <= RIC - 2);
    test_done();
  end
endmodule

bind fisrc_core fisrc_core_properties #(.RELEASE_CYC(RELEASE_CYC), .RELEASE_ID_CYC(RELEASE_ID_CYC),
  .RESET_CYC(RESET_CYC)) u_props (.clk, .srst, .sclk, .cs_n, .mosi, .miso, .miso_oe,
  .secreg_lock_bits, .write_in_progress, .write_enable_latch, .deep_power_down,
  .reset_armed, .cmd_blocked, .sw_reset_pulse);
